// ### src/scrt_map.svh
// register offsets, field positions, reset values and divider counts for the timer block
// assumes a 32-bit axi4-lite slave, one register per aligned word
`ifndef SCRT_MAP_SVH
`define SCRT_MAP_SVH

`define SCRT_CTRL_OFS      8'h00
`define SCRT_CFG_OFS       8'h04
`define SCRT_CNT_LO_OFS    8'h08
`define SCRT_CNT_HI_OFS    8'h0c
`define SCRT_RLD_LO_OFS    8'h10
`define SCRT_RLD_HI_OFS    8'h14

`define SCRT_CTRL_OVF_BIT  7
`define SCRT_CTRL_EXF_BIT  6
`define SCRT_CTRL_EXEN_BIT 3
`define SCRT_CTRL_RUN_BIT  2
`define SCRT_CTRL_CT_BIT   1
`define SCRT_CTRL_CPRL_BIT 0
`define SCRT_CTRL_MASK     8'hcf

`define SCRT_CFG_CSEL_HI   4
`define SCRT_CFG_CSEL_LO   3
`define SCRT_CFG_TOG_BIT   2
`define SCRT_CFG_TOE_BIT   1
`define SCRT_CFG_DECREMENT_ENABLE_BIT  0
`define SCRT_CFG_MASK      8'h1f

`define SCRT_RESET_BYTE    8'h00
`define SCRT_DIV12_CNT     4'd12
`define SCRT_DIV8_CNT      4'd8
`define SCRT_DIV2_CNT      4'd2

`endif

// ### src/scrt_pkg.sv
// types shared by the timer block
// assumes scrt_map.svh defines the offsets and fields
package scrt_pkg;

   typedef enum logic [1:0] {
      SCRT_CK_DIV12,
      SCRT_CK_SYS,
      SCRT_CK_EXT8,
      SCRT_CK_DIV2
   } scrt_csel_t;

   typedef enum logic [1:0] {
      SCRT_BUS_IDLE,
      SCRT_BUS_WRESP,
      SCRT_BUS_RRESP
   } scrt_bus_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } scrt_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } scrt_axi_rsp_t;

   typedef struct packed {
      logic       overflow_event;
      logic       adc_start;
      logic       dac_update;
      logic       uart0_baud_tick;
      logic       irq_request;
      logic       toggle_pin_out;
      logic       toggle_pin_oe;
   } scrt_evt_t;

   typedef struct packed {
      logic [1:0]  cnt_sync;
      logic [1:0]  trg_sync;
      logic [1:0]  ext_sync;
      logic        cnt_prev;
      logic        trg_prev;
      logic        ext_prev;
      logic [3:0]  pre_cnt;
      logic [3:0]  ext_cnt;
      logic        ext_tick;
      logic [15:0] count;
      logic [15:0] reload;
      logic        ovf_flag;
      logic        ext_flag;
      logic        ext_en;
      logic        run_bit;
      logic        counter_select;
      logic        capture_reload_select;
      logic [1:0]  clock_select;
      logic        toggle_state;
      logic        toggle_output_enable;
      logic        decrement_enable;
      logic        ovf_pulse;
      scrt_bus_t   bus;
      logic        aw_held;
      logic        w_held;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic [1:0]  bresp;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } scrt_state_t;

endpackage

// ### src/scrt_timer.sv
// one 16-bit capture/reload timer with axi4-lite register access
// assumes pins come from the crossbar asynchronously; timer 3 is fed the timer 2 pins outside
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "scrt_map.svh"

// Behaviour
// R01: 16-bit count in two byte halves
// R02: toggle only when HAS_TOGGLE set
// R03: clock: system_clock, /2, /12, ext/8
// R04: counter mode counts count-pin falling edges
// R05: timer 3 shares timer 2 pins
// R06: overflow pulses to adc and dac
// R07: overflow usable as uart0 baud tick
// R08: decrement enable: trigger pin sets direction
// R09: with decrement, trigger pin makes no events
// R10: trigger falling edge captures count
// R11: capture sets external flag, interrupt request
// R12: capture up overflow sets overflow flag
// R13: capture down 0000 to ffff underflows
// R14: capture needs run; exen 0 ignores pin
// R15: reload mode when select 0; run starts
// R16: up overflow loads reload value
// R17: reload on trigger rising edge
// R18: down match reload loads ffff
// R19: reload mode external flag toggles
// R20: toggle inverts on overflow/underflow
// R21: clock select encoding 00..11
// R22: toggle state readable and writable
// R23: toggle reaches pin only when enabled
// R24: pins synchronised, edges as pulses
// R25: flags cleared only by software; reload-mode wraps toggle the external flag, so hardware clears it too
module scrt_timer #(
   parameter bit HAS_TOGGLE = 1'b1
) (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire scrt_pkg::scrt_axi_req_t axi_req,
   output scrt_pkg::scrt_axi_rsp_t      axi_rsp,
   input  wire logic                    ext_count_pin,
   input  wire logic                    ext_trigger_pin,
   input  wire logic                    ext_osc_clk,
   output scrt_pkg::scrt_evt_t          evt
);

   scrt_pkg::scrt_state_t s_reg;
   scrt_pkg::scrt_state_t s_next;

   logic        cnt_fall;
   logic        trg_fall;
   logic        trg_rise;
   logic        tick;
   logic        count_up;
   logic        ovf;
   logic        capture;
   logic        reload_ev;
   logic [15:0] count_cur;
   logic [7:0]  ctrl_rd;
   logic [7:0]  cfg_rd;
   logic        wr_go;
   logic        rd_go;
   logic [7:0]  wbyte;
   logic [7:0]  raddr;

   // byte lane 0 merge with strobe
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
      lane0 = st[0] ? d[7:0] : old;
   endfunction

   // R01: low and high halves of the live count and of the reload value
   function automatic logic [15:0] set_half(input logic [15:0] v, input logic hi,
                                            input logic [7:0] b);
      set_half = hi ? {b, v[7:0]} : {v[15:8], b};
   endfunction

   always_comb begin
      // R24: edges only from second sync stage onward
      cnt_fall  = s_reg.cnt_prev & ~s_reg.cnt_sync[1];
      trg_fall  = s_reg.trg_prev & ~s_reg.trg_sync[1];
      trg_rise  = ~s_reg.trg_prev & s_reg.trg_sync[1];
      // R03: R21: R04: clock source choice
      if (s_reg.counter_select) begin
         tick = cnt_fall;
      end else begin
         case (scrt_pkg::scrt_csel_t'(s_reg.clock_select))
            scrt_pkg::SCRT_CK_DIV12: tick = (s_reg.pre_cnt == `SCRT_DIV12_CNT - 4'd1);
            scrt_pkg::SCRT_CK_SYS:   tick = 1'b1;
            scrt_pkg::SCRT_CK_EXT8:  tick = s_reg.ext_tick;
            scrt_pkg::SCRT_CK_DIV2:  tick = s_reg.pre_cnt[0];
            default:                 tick = 1'b0;
         endcase
      end
      // R15: R14: run gates ticks
      tick = tick & s_reg.run_bit;
      // R08: direction from trigger level
      count_up = ~s_reg.decrement_enable | s_reg.trg_sync[1];
      count_cur = s_reg.count;
      if (!count_up) begin
         // R18: R13: down terminal value per mode
         ovf = tick & (s_reg.capture_reload_select ? (count_cur == 16'h0000)
                                                   : (count_cur == s_reg.reload));
      end else begin
         // R12: R16: up overflow at ffff
         ovf = tick & (count_cur == 16'hffff);
      end
      // R09: R14: R10: R17: pin events gated
      capture   = s_reg.capture_reload_select & s_reg.run_bit & s_reg.ext_en
                  & ~s_reg.decrement_enable & trg_fall;
      reload_ev = ~s_reg.capture_reload_select & s_reg.ext_en
                  & ~s_reg.decrement_enable & trg_rise;
      ctrl_rd = {s_reg.ovf_flag, s_reg.ext_flag, 2'b00, s_reg.ext_en, s_reg.run_bit,
                 s_reg.counter_select, s_reg.capture_reload_select};
      // R22: toggle state readback
      cfg_rd  = {3'b000, s_reg.clock_select, HAS_TOGGLE & s_reg.toggle_state,
                 s_reg.toggle_output_enable, s_reg.decrement_enable};
      wr_go = (s_reg.bus == scrt_pkg::SCRT_BUS_IDLE) & s_reg.aw_held & s_reg.w_held;
      rd_go = (s_reg.bus == scrt_pkg::SCRT_BUS_IDLE) & ~wr_go & axi_req.arvalid;
      wbyte = 8'h00;
      raddr = axi_req.araddr[7:0];

      s_next = s_reg;
      // R05: shareable pin inputs
      s_next.cnt_sync = {s_reg.cnt_sync[0], ext_count_pin};
      s_next.trg_sync = {s_reg.trg_sync[0], ext_trigger_pin};
      s_next.ext_sync = {s_reg.ext_sync[0], ext_osc_clk};
      s_next.cnt_prev = s_reg.cnt_sync[1];
      s_next.trg_prev = s_reg.trg_sync[1];
      s_next.ext_prev = s_reg.ext_sync[1];
      s_next.pre_cnt  = (s_reg.pre_cnt == `SCRT_DIV12_CNT - 4'd1) ? 4'd0
                        : s_reg.pre_cnt + 4'd1;
      // ext/8 counted on rising edges of the synced oscillator
      s_next.ext_tick = 1'b0;
      if (s_reg.ext_sync[1] & ~s_reg.ext_prev) begin
         if (s_reg.ext_cnt == `SCRT_DIV8_CNT - 4'd1) begin
            s_next.ext_cnt  = 4'd0;
            s_next.ext_tick = 1'b1;
         end else begin
            s_next.ext_cnt = s_reg.ext_cnt + 4'd1;
         end
      end

      // count path
      if (tick) begin
         if (ovf & ~s_reg.capture_reload_select) begin
            s_next.count = count_up ? s_reg.reload : 16'hffff;
         end else begin
            s_next.count = count_up ? s_reg.count + 16'd1 : s_reg.count - 16'd1;
         end
      end
      if (reload_ev) begin
         s_next.count = s_reg.reload;
      end
      if (capture) begin
         s_next.reload = s_reg.count;
      end
      s_next.ovf_pulse = ovf;
      // R20: toggle on every wrap
      if (ovf & HAS_TOGGLE) begin
         s_next.toggle_state = ~s_reg.toggle_state;
      end

      // register writes first so hardware sets below win
      s_next.bresp = 2'b00;
      if (wr_go) begin
         wbyte = s_reg.w_data[7:0];
         s_next.aw_held = 1'b0;
         s_next.w_held  = 1'b0;
         s_next.bus     = scrt_pkg::SCRT_BUS_WRESP;
         if (s_reg.w_strb[0]) begin
            case (s_reg.aw_addr)
               `SCRT_CTRL_OFS: begin
                  s_next.ovf_flag              = wbyte[`SCRT_CTRL_OVF_BIT];
                  s_next.ext_flag              = wbyte[`SCRT_CTRL_EXF_BIT];
                  s_next.ext_en                = wbyte[`SCRT_CTRL_EXEN_BIT];
                  s_next.run_bit               = wbyte[`SCRT_CTRL_RUN_BIT];
                  s_next.counter_select        = wbyte[`SCRT_CTRL_CT_BIT];
                  s_next.capture_reload_select = wbyte[`SCRT_CTRL_CPRL_BIT];
               end
               `SCRT_CFG_OFS: begin
                  s_next.clock_select = wbyte[`SCRT_CFG_CSEL_HI:`SCRT_CFG_CSEL_LO];
                  // R22: forced toggle level
                  s_next.toggle_state         = HAS_TOGGLE & wbyte[`SCRT_CFG_TOG_BIT];
                  s_next.toggle_output_enable = HAS_TOGGLE & wbyte[`SCRT_CFG_TOE_BIT];
                  s_next.decrement_enable     = wbyte[`SCRT_CFG_DECREMENT_ENABLE_BIT];
               end
               `SCRT_CNT_LO_OFS: s_next.count  = set_half(s_next.count, 1'b0, wbyte);
               `SCRT_CNT_HI_OFS: s_next.count  = set_half(s_next.count, 1'b1, wbyte);
               `SCRT_RLD_LO_OFS: s_next.reload = set_half(s_next.reload, 1'b0, wbyte);
               `SCRT_RLD_HI_OFS: s_next.reload = set_half(s_next.reload, 1'b1, wbyte);
               default: s_next.bresp = 2'b10;
            endcase
         end else if (s_reg.aw_addr > `SCRT_RLD_HI_OFS || s_reg.aw_addr[1:0] != 2'b00) begin
            s_next.bresp = 2'b10;
         end
      end else begin
         s_next.bresp = s_reg.bresp;
      end

      // R25: R12: R13: R16: flag set wins over clear
      if (ovf) begin
         s_next.ovf_flag = 1'b1;
      end
      // R11: capture marks external flag
      if (capture | (reload_ev & trg_rise)) begin
         s_next.ext_flag = 1'b1;
      end
      // R19: 17th bit in reload mode
      if (ovf & ~s_reg.capture_reload_select) begin
         s_next.ext_flag = ~s_next.ext_flag;
      end

      // axi4-lite channel capture
      if (axi_req.awvalid & ~s_reg.aw_held & (s_reg.bus == scrt_pkg::SCRT_BUS_IDLE)) begin
         s_next.aw_held = 1'b1;
         s_next.aw_addr = axi_req.awaddr[7:0];
      end
      if (axi_req.wvalid & ~s_reg.w_held & (s_reg.bus == scrt_pkg::SCRT_BUS_IDLE)) begin
         s_next.w_held = 1'b1;
         s_next.w_data = axi_req.wdata;
         s_next.w_strb = axi_req.wstrb;
      end
      if (rd_go) begin
         s_next.bus   = scrt_pkg::SCRT_BUS_RRESP;
         s_next.rresp = 2'b00;
         case (raddr)
            `SCRT_CTRL_OFS:   s_next.rdata = {24'h000000, ctrl_rd};
            `SCRT_CFG_OFS:    s_next.rdata = {24'h000000, cfg_rd};
            `SCRT_CNT_LO_OFS: s_next.rdata = {24'h000000, s_reg.count[7:0]};
            `SCRT_CNT_HI_OFS: s_next.rdata = {24'h000000, s_reg.count[15:8]};
            `SCRT_RLD_LO_OFS: s_next.rdata = {24'h000000, s_reg.reload[7:0]};
            `SCRT_RLD_HI_OFS: s_next.rdata = {24'h000000, s_reg.reload[15:8]};
            default: begin
               s_next.rdata = 32'h00000000;
               s_next.rresp = 2'b10;
            end
         endcase
      end
      case (s_reg.bus)
         scrt_pkg::SCRT_BUS_WRESP: if (axi_req.bready) s_next.bus = scrt_pkg::SCRT_BUS_IDLE;
         scrt_pkg::SCRT_BUS_RRESP: if (axi_req.rready) s_next.bus = scrt_pkg::SCRT_BUS_IDLE;
         default: ;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg     <= '0;
         s_reg.bus <= scrt_pkg::SCRT_BUS_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // channel readies only while idle, so one write or one read at a time
   always_comb begin
      axi_rsp.awready = (s_reg.bus == scrt_pkg::SCRT_BUS_IDLE) & ~s_reg.aw_held;
      axi_rsp.wready  = (s_reg.bus == scrt_pkg::SCRT_BUS_IDLE) & ~s_reg.w_held;
      axi_rsp.bvalid  = (s_reg.bus == scrt_pkg::SCRT_BUS_WRESP);
      axi_rsp.bresp   = s_reg.bresp;
      axi_rsp.arready = (s_reg.bus == scrt_pkg::SCRT_BUS_IDLE) & ~wr_go;
      axi_rsp.rvalid  = (s_reg.bus == scrt_pkg::SCRT_BUS_RRESP);
      axi_rsp.rdata   = s_reg.rdata;
      axi_rsp.rresp   = s_reg.rresp;
   end

   always_comb begin
      // R06: R07: wrap pulse fanned to adc, dac, uart0
      evt.overflow_event  = s_reg.ovf_pulse;
      evt.adc_start       = s_reg.ovf_pulse;
      evt.dac_update      = s_reg.ovf_pulse;
      evt.uart0_baud_tick = s_reg.ovf_pulse;
      // R11: R12: level request while overflow flag stands, or external flag in capture mode
      evt.irq_request     = s_reg.ovf_flag | (s_reg.ext_flag & s_reg.capture_reload_select);
      // R02: R23: pin gated by output enable
      evt.toggle_pin_out  = HAS_TOGGLE & s_reg.toggle_output_enable & s_reg.toggle_state;
      evt.toggle_pin_oe   = HAS_TOGGLE & s_reg.toggle_output_enable;
   end

endmodule

// ### test/scrt_pins_model.sv
// pin side of the timer: count pin, trigger pin, free oscillator
// assumes the bench calls its tasks between bus accesses
`timescale 1ns/100ps
module scrt_pins_model (
   input  wire logic clk,
   output logic      count_pin,
   output logic      trig_pin,
   output logic      osc_clk
);
   initial begin
      count_pin = 1'b1;
      trig_pin = 1'b1;
      osc_clk = 1'b0;
      // well under half of clk
      forever #23.5 osc_clk = ~osc_clk;
   end

   // levels held four cycles so the synchronisers never miss one
   task automatic count_edges(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk);
         count_pin <= 1'b0;
         repeat (4) @(posedge clk);
         count_pin <= 1'b1;
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic set_trig(input logic v);
      @(posedge clk);
      trig_pin <= v;
      repeat (6) @(posedge clk);
   endtask
endmodule

// ### test/scrt_timer_monitor.sv
// checker on the timer ports: bus answers and event outputs
// assumes it is bound onto every scrt_timer instance
`timescale 1ns/100ps
module scrt_timer_monitor #(
   parameter bit HAS_TOGGLE = 1'b1
) (
   input wire logic                    clk,
   input wire logic                    nrst,
   input wire scrt_pkg::scrt_axi_req_t axi_req,
   input wire scrt_pkg::scrt_axi_rsp_t axi_rsp,
   input wire logic                    ext_count_pin,
   input wire logic                    ext_trigger_pin,
   input wire logic                    ext_osc_clk,
   input wire scrt_pkg::scrt_evt_t     evt
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);

   chk_pin_gating: assert property (!evt.toggle_pin_oe |-> !evt.toggle_pin_out)
      else $error("toggle pin active while disabled");
   chk_evt_fanout: assert property (
      {evt.adc_start, evt.dac_update, evt.uart0_baud_tick} == {3{evt.overflow_event}})
      else $error("trigger outputs differ from overflow");
   chk_irq_on_wrap: assert property (evt.overflow_event |-> ##[0:1] evt.irq_request)
      else $error("wrap without interrupt request");
   chk_flag_sticky: assert property (
      evt.irq_request |=> evt.irq_request || $rose(axi_rsp.bvalid))
      else $error("interrupt request dropped without a write");
   chk_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid) else $error("write not answered");
   chk_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid)
      else $error("read not answered");
   chk_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid
      && $stable(axi_rsp.bresp)) else $error("write response withdrawn");
   chk_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid
      && $stable(axi_rsp.rdata)) else $error("read data withdrawn");
endmodule

bind scrt_timer scrt_timer_monitor #(.HAS_TOGGLE(HAS_TOGGLE)) i_mon (.clk(clk), .nrst(nrst),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .ext_count_pin(ext_count_pin),
   .ext_trigger_pin(ext_trigger_pin), .ext_osc_clk(ext_osc_clk), .evt(evt));

// ### test/test_sixteen_bit_capture_reload_timer.sv
// bench for one timer with toggle output: register table, reload, down count, capture, reset
// assumes scrt_pins_model stands in for the crossbar pins
`timescale 1ns/100ps
module test_sixteen_bit_capture_reload_timer;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [1:0] resp;
   } scrt_row_t;

   logic                    clk;
   logic                    nrst;
   scrt_pkg::scrt_axi_req_t axi_req;
   scrt_pkg::scrt_axi_rsp_t axi_rsp;
   scrt_pkg::scrt_evt_t     evt;
   logic                    count_pin;
   logic                    trig_pin;
   logic                    osc_clk;
   logic [31:0]             rdat;
   logic [1:0]              resp;
   int                      bad_count = 0;
   int                      total_checks = 0;
   int                      gap;
   logic [3:0]              strb = 4'hf;
   scrt_row_t               rows [9] = '{
      '{8'h04, 8'hff, 8'h1f, 2'h0}, '{8'h04, 8'h04, 8'h04, 2'h0},
      '{8'h10, 8'hf0, 8'hf0, 2'h0}, '{8'h14, 8'hff, 8'hff, 2'h0},
      '{8'h08, 8'hfe, 8'hfe, 2'h0}, '{8'h0c, 8'hff, 8'hff, 2'h0},
      '{8'h00, 8'h30, 8'h00, 2'h0}, '{8'h18, 8'h5a, 8'h00, 2'h2},
      '{8'h06, 8'h5a, 8'h00, 2'h2}};

   scrt_timer #(.HAS_TOGGLE(1'b1)) i_dut (.clk(clk), .nrst(nrst), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .ext_count_pin(count_pin), .ext_trigger_pin(trig_pin),
      .ext_osc_clk(osc_clk), .evt(evt));
   scrt_pins_model i_pins (.clk(clk), .count_pin(count_pin), .trig_pin(trig_pin),
      .osc_clk(osc_clk));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic timed_out();
      bad_count++;
      $display("mismatch wait expected answer seen none");
      print_verdict();
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int   n;
      logic aw;
      logic w;
      logic ar;
      aw = wr;
      w = wr;
      ar = !wr;
      axi_req.awaddr <= {24'h0, a};
      axi_req.araddr <= {24'h0, a};
      // upper bytes carry junk; only lane 0 may land
      axi_req.wdata <= {24'ha5a5a5, d};
      axi_req.wstrb <= strb;
      for (n = 0; aw || w || ar; n++) begin
         axi_req.awvalid <= aw;
         axi_req.wvalid <= w;
         axi_req.arvalid <= ar;
         @(posedge clk);
         aw = aw && axi_rsp.awready !== 1'b1;
         w = w && axi_rsp.wready !== 1'b1;
         ar = ar && axi_rsp.arready !== 1'b1;
         if (n > 40) timed_out();
      end
      axi_req.awvalid <= 1'b0;
      axi_req.wvalid <= 1'b0;
      axi_req.arvalid <= 1'b0;
      // ready raised late so the answer must stand a cycle
      for (n = 0; (wr ? axi_rsp.bvalid : axi_rsp.rvalid) !== 1'b1; n++) begin
         @(posedge clk);
         if (n > 40) timed_out();
      end
      axi_req.bready <= wr;
      axi_req.rready <= !wr;
      @(posedge clk);
      rdat = axi_rsp.rdata;
      resp = wr ? axi_rsp.bresp : axi_rsp.rresp;
      axi_req.bready <= 1'b0;
      axi_req.rready <= 1'b0;
   endtask

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      bus_op(1'b1, a, d);
   endtask

   task automatic get_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
      bus_op(1'b0, a, 8'h00);
      check(nm, rdat, {24'h0, e});
   endtask

   task automatic wait_ovf();
      int n;
      for (n = 0; evt.overflow_event !== 1'b1; n++) begin
         @(posedge clk);
         if (n > 1000) timed_out();
      end
      gap = n;
   endtask

   // cycles between two wraps with a fresh clock select
   task automatic gap_chk(input string nm, input logic [7:0] cfg, input int lo, input int hi);
      put(8'h04, cfg);
      wait_ovf();
      @(posedge clk);
      wait_ovf();
      check(nm, (gap + 1 >= lo && gap + 1 <= hi) ? lo : gap + 1, lo);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      nrst = 1'b0;
      axi_req = '0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         bus_op(1'b1, rows[i].addr, rows[i].wdata);
         check("wresp", 32'(resp), 32'(rows[i].resp));
         bus_op(1'b0, rows[i].addr, 8'h00);
         check("rdata", rdat, {24'h0, rows[i].rdata});
         check("rresp", 32'(resp), 32'(rows[i].resp));
      end
      check("pin off", 32'(evt.toggle_pin_out), 32'h0);
      // reload fff0, count fffe, system clock, square wave
      put(8'h04, 8'h0e);
      check("pin forced", 32'(evt.toggle_pin_out), 32'h1);
      check("pin oe", 32'(evt.toggle_pin_oe), 32'h1);
      put(8'h00, 8'h04);
      wait_ovf();
      get_chk("ctrl wrap1", 8'h00, 8'hc4);
      get_chk("reloaded", 8'h0c, 8'hff);
      check("pin wrap1", 32'(evt.toggle_pin_out), 32'h0);
      wait_ovf();
      check("pin wrap2", 32'(evt.toggle_pin_out), 32'h1);
      get_chk("ctrl wrap2", 8'h00, 8'h84);
      put(8'h00, 8'h00);
      check("irq clear", 32'(evt.irq_request), 32'h0);
      // down count from 0013 to reload 0010
      i_pins.set_trig(1'b0);
      put(8'h04, 8'h09);
      put(8'h10, 8'h10);
      put(8'h14, 8'h00);
      put(8'h08, 8'h13);
      put(8'h0c, 8'h00);
      put(8'h00, 8'h04);
      wait_ovf();
      get_chk("underflow", 8'h0c, 8'hff);
      check("irq down", 32'(evt.irq_request), 32'h1);
      put(8'h00, 8'h00);
      // capture five pin counts
      put(8'h04, 8'h00);
      i_pins.set_trig(1'b1);
      put(8'h08, 8'h00);
      put(8'h0c, 8'h00);
      put(8'h00, 8'h0f);
      i_pins.count_edges(5);
      i_pins.set_trig(1'b0);
      get_chk("cap low", 8'h10, 8'h05);
      get_chk("cap high", 8'h14, 8'h00);
      get_chk("ctrl cap", 8'h00, 8'h4f);
      check("irq cap", 32'(evt.irq_request), 32'h1);
      put(8'h00, 8'h07);
      i_pins.set_trig(1'b1);
      i_pins.set_trig(1'b0);
      get_chk("no cap", 8'h10, 8'h05);
      get_chk("no flag", 8'h00, 8'h07);
      // lane 0 strobe low: write ignored, still okay
      strb = 4'he;
      put(8'h10, 8'h77);
      check("strb resp", 32'(resp), 32'h0);
      strb = 4'hf;
      get_chk("strb off", 8'h10, 8'h05);
      // reload mode, stopped: trigger rising edge reloads
      put(8'h00, 8'h08);
      put(8'h10, 8'h34);
      put(8'h14, 8'h12);
      i_pins.set_trig(1'b1);
      get_chk("reload edge", 8'h08, 8'h34);
      get_chk("reload flag", 8'h00, 8'h48);
      check("irq reload", 32'(evt.irq_request), 32'h0);
      // decrement enabled: trigger only steers direction
      put(8'h00, 8'h08);
      put(8'h04, 8'h01);
      put(8'h08, 8'h00);
      i_pins.set_trig(1'b0);
      i_pins.set_trig(1'b1);
      get_chk("dir only", 8'h08, 8'h00);
      get_chk("dir no flag", 8'h00, 8'h08);
      // wrap period of 16 ticks under each clock select
      put(8'h08, 8'hf0);
      put(8'h0c, 8'hff);
      put(8'h10, 8'hf0);
      put(8'h14, 8'hff);
      put(8'h00, 8'h04);
      gap_chk("sys gap", 8'h08, 16, 16);
      gap_chk("div2 gap", 8'h18, 32, 32);
      gap_chk("div12 gap", 8'h00, 192, 192);
      gap_chk("ext8 gap", 8'h10, 600, 603);
      // second reset in mid-run
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check("evt reset", 32'(evt), 32'h0);
      for (int i = 0; i < 6; i++) begin
         get_chk("reset value", 8'(4 * i), 8'h00);
      end
      print_verdict();
   end
endmodule
